// file: gsfp_consts.svh
// Constants of the general-purpose pin, strap and flag port.
// Behaviour
// (RQ1) Each pin has its own direction bit.
// (RQ2) Data reads input levels, drives output pins.
// (RQ3) Reset makes all eight pins inputs.
// (RQ4) Board holds pin 7 low at reset.
// (RQ5) Pins 2..0 captured as boot mode.
// (RQ6) After boot, strap pins are ordinary pins.
// (RQ7) Pin 4 drives handshake during some boots.
// (RQ8) After boot, application may reassign pin 4.
// (RQ9) Pin 4 at reset loads clock source bit.
// (RQ10) Clock source bit selects oscillator or external.
// (RQ11) Pin 6 level selects multiplexed port function.
// (RQ12) Flag set, cleared, or loaded from status.
// (RQ13) Flag output is one during reset.
// (RQ14) Fast peripheral clock is source divided by four.
// (RQ15) Every pin input passes two synchroniser stages.
`ifndef GSFP_CONSTS_SVH
`define GSFP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define GSFP_OFS_DIR        12'h000
`define GSFP_OFS_DATA       12'h004
`define GSFP_OFS_CLKMODE    12'h008
`define GSFP_OFS_BOOT       12'h00c
`define GSFP_OFS_FLAGCMD    12'h010
`define GSFP_OFS_STATUS1    12'h014

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define GSFP_CLKSEL_BIT     0
`define GSFP_BOOT_HSVAL_BIT 0
`define GSFP_BOOT_DONE_BIT  1
`define GSFP_BOOT_MODE_LSB  4
`define GSFP_BOOT_MUX_BIT   7
`define GSFP_FLAG_SET_BIT   0
`define GSFP_FLAG_CLR_BIT   1
`define GSFP_STATUS1_FLAG   0
`define GSFP_PIN_HANDSHAKE  4
`define GSFP_PIN_MUXSEL     6

// ----------------------------------------------------------------------------
// Reset values and counts.
// ----------------------------------------------------------------------------
`define GSFP_DIR_RESET      8'h00
`define GSFP_DATA_RESET     8'h00
`define GSFP_FLAG_RESET     1'b1
`define GSFP_HSVAL_RESET    1'b1
`define GSFP_HS_MODES       8'hf0
`define GSFP_FAST_DIV       2'h3

`endif

// file: gsfp_pkg.sv
// Types of the general-purpose pin, strap and flag port.
package gsfp_pkg;

    typedef enum logic {
        GSFP_BOOTING,
        GSFP_RUNNING
    } gsfp_phase_e;

    typedef logic [7:0] gsfp_pins_t;

endpackage : gsfp_pkg

// file: gsfp_gpio_port.sv
// Eight-pin general-purpose port with boot straps, clock select and flag.
`timescale 1ns/100ps
`include "gsfp_consts.svh"

module gsfp_gpio_port (
    input  wire logic                core_clk,
    input  wire logic                rst,
    // APB slave.
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // General-purpose pins.
    input  wire gsfp_pkg::gsfp_pins_t gpioIn,
    output gsfp_pkg::gsfp_pins_t     gpioOut,
    output gsfp_pkg::gsfp_pins_t     gpioOe,
    // Clock sources, sampled as ordinary inputs.
    input  wire logic                oscillatorClock,
    input  wire logic                externalClockInput,
    // Status toward the rest of the device.
    output logic [2:0]               bootModeSelect,
    output logic                     bootActive,
    output logic                     clockSourceSelectBit,
    output logic                     fastPeripheralClockEn,
    output logic                     parallelHostPortSel,
    output logic                     externalFlagOutput
);

    // ------------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------------
    gsfp_pkg::gsfp_pins_t pinMeta_q;
    gsfp_pkg::gsfp_pins_t pinSync_q;
    logic [1:0]           clkMeta_q;
    logic [1:0]           clkSync_q;

    always_ff @(posedge core_clk) begin
        pinMeta_q <= gpioIn;                                  // [RQ15]
        pinSync_q <= pinMeta_q;                               // [RQ15]
    end

    always_ff @(posedge core_clk) begin
        clkMeta_q <= {externalClockInput, oscillatorClock};
        clkSync_q <= clkMeta_q;
    end

    // ------------------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------------------
    logic setupPhase;
    logic accessPhase;
    logic wrEn;
    logic hitDir;
    logic hitData;
    logic hitClkMode;
    logic hitBoot;
    logic hitFlagCmd;
    logic hitStatus1;
    logic hitAny;

    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign hitDir      = paddr == `GSFP_OFS_DIR;
    assign hitData     = paddr == `GSFP_OFS_DATA;
    assign hitClkMode  = paddr == `GSFP_OFS_CLKMODE;
    assign hitBoot     = paddr == `GSFP_OFS_BOOT;
    assign hitFlagCmd  = paddr == `GSFP_OFS_FLAGCMD;
    assign hitStatus1  = paddr == `GSFP_OFS_STATUS1;
    assign hitAny      = hitDir || hitData || hitClkMode || hitBoot
                         || hitFlagCmd || hitStatus1;
    assign wrEn        = accessPhase && pwrite && hitAny;

    // The slave never inserts wait states.
    assign pready  = 1'b1;
    assign pslverr = accessPhase && !hitAny;

    // ------------------------------------------------------------------------
    // Direction and data registers.
    // ------------------------------------------------------------------------
    gsfp_pkg::gsfp_pins_t dir_q;
    gsfp_pkg::gsfp_pins_t data_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dir_q <= `GSFP_DIR_RESET;                         // [RQ3]
        end else if (wrEn && hitDir) begin
            dir_q <= pwdata[7:0];                             // [RQ1]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_q <= `GSFP_DATA_RESET;
        end else if (wrEn && hitData) begin
            data_q <= pwdata[7:0];                            // [RQ2]
        end
    end

    // ------------------------------------------------------------------------
    // Straps caught while reset is held; the last sample before release stays.
    // ------------------------------------------------------------------------
    logic [2:0] bootMode_q;
    logic       clkSel_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bootMode_q <= pinSync_q[2:0];                     // [RQ5]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clkSel_q <= pinSync_q[`GSFP_PIN_HANDSHAKE];       // [RQ9]
        end else if (wrEn && hitClkMode) begin
            clkSel_q <= pwdata[`GSFP_CLKSEL_BIT];             // [RQ10]
        end
    end

    // ------------------------------------------------------------------------
    // Boot phase and handshake pin.
    // ------------------------------------------------------------------------
    gsfp_pkg::gsfp_phase_e phase_q;
    logic                  hsVal_q;
    logic                  hsMode;
    logic                  hsDrive;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_q <= gsfp_pkg::GSFP_BOOTING;
        end else begin
            unique case (phase_q)
                gsfp_pkg::GSFP_BOOTING: begin
                    if (wrEn && hitBoot && pwdata[`GSFP_BOOT_DONE_BIT]) begin
                        phase_q <= gsfp_pkg::GSFP_RUNNING;    // [RQ6]
                    end
                end
                gsfp_pkg::GSFP_RUNNING: begin
                    phase_q <= gsfp_pkg::GSFP_RUNNING;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hsVal_q <= `GSFP_HSVAL_RESET;
        end else if (wrEn && hitBoot) begin
            hsVal_q <= pwdata[`GSFP_BOOT_HSVAL_BIT];
        end
    end

    assign hsMode  = 1'(`GSFP_HS_MODES >> bootMode_q);
    assign hsDrive = (phase_q == gsfp_pkg::GSFP_BOOTING) && hsMode;   // [RQ7]

    // ------------------------------------------------------------------------
    // Pin drivers.
    // ------------------------------------------------------------------------
    gsfp_pkg::gsfp_pins_t pinOe_d;
    gsfp_pkg::gsfp_pins_t pinOut_d;
    gsfp_pkg::gsfp_pins_t pinOe_q;
    gsfp_pkg::gsfp_pins_t pinOut_q;

    always_comb begin
        pinOe_d  = dir_q;                                     // [RQ1]
        pinOut_d = data_q;                                    // [RQ2]
        if (phase_q == gsfp_pkg::GSFP_BOOTING) begin
            // Strap pins stay inputs until the boot is declared done.
            pinOe_d[2:0] = 3'h0;                              // [RQ6]
        end
        if (hsDrive) begin
            pinOe_d[`GSFP_PIN_HANDSHAKE]  = 1'b1;             // [RQ7]
            pinOut_d[`GSFP_PIN_HANDSHAKE] = hsVal_q;
        end
        // Once running, pin 4 follows the direction and data registers.
    end                                                       // [RQ8]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinOe_q  <= 8'h00;                                // [RQ3]
            pinOut_q <= 8'h00;
        end else begin
            pinOe_q  <= pinOe_d;
            pinOut_q <= pinOut_d;
        end
    end

    assign gpioOe  = pinOe_q;
    assign gpioOut = pinOut_q;

    // ------------------------------------------------------------------------
    // Multiplexed port function select.
    // ------------------------------------------------------------------------
    logic muxSel_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            muxSel_q <= 1'b0;
        end else begin
            muxSel_q <= pinSync_q[`GSFP_PIN_MUXSEL];          // [RQ11]
        end
    end

    assign parallelHostPortSel = muxSel_q;

    // ------------------------------------------------------------------------
    // Fast peripheral clock enable: selected source divided by four.
    // ------------------------------------------------------------------------
    logic       srcLevel;
    logic       srcPrev_q;
    logic       srcRise;
    logic [1:0] div_q;
    logic       fastEn_q;

    assign srcLevel = clkSel_q ? clkSync_q[1] : clkSync_q[0]; // [RQ10]
    assign srcRise  = srcLevel && !srcPrev_q;

    always_ff @(posedge core_clk) begin
        srcPrev_q <= srcLevel;
    end

    // The count is cleared while reset is held, since a count that starts unknown stays so.
    // The first pulse after release comes on the fourth source edge.
    always_ff @(posedge core_clk) begin
        fastEn_q <= 1'b0;
        if (rst) begin
            div_q <= 2'h0;
        end else if (srcRise) begin
            div_q <= div_q + 2'h1;                            // [RQ14]
            fastEn_q <= div_q == `GSFP_FAST_DIV;              // [RQ14]
        end
    end

    assign fastPeripheralClockEn = fastEn_q;

    // ------------------------------------------------------------------------
    // External flag.
    // ------------------------------------------------------------------------
    logic flag_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_q <= `GSFP_FLAG_RESET;                       // [RQ13]
        end else if (wrEn && hitStatus1) begin
            flag_q <= pwdata[`GSFP_STATUS1_FLAG];             // [RQ12]
        end else if (wrEn && hitFlagCmd && pwdata[`GSFP_FLAG_SET_BIT]) begin
            flag_q <= 1'b1;                                   // [RQ12]
        end else if (wrEn && hitFlagCmd && pwdata[`GSFP_FLAG_CLR_BIT]) begin
            flag_q <= 1'b0;                                   // [RQ12]
        end
    end

    assign externalFlagOutput = rst ? 1'b1 : flag_q;         // [RQ13]

    // ------------------------------------------------------------------------
    // Read data, registered in the setup phase.
    // ------------------------------------------------------------------------
    logic [31:0] rd_d;
    logic [31:0] rd_q;
    gsfp_pkg::gsfp_pins_t pinView;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pinView[i] = pinOe_q[i] ? data_q[i] : pinSync_q[i];   // [RQ2]
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (hitDir) begin
            rd_d[7:0] = dir_q;
        end
        if (hitData) begin
            rd_d[7:0] = pinView;
        end
        if (hitClkMode) begin
            rd_d[`GSFP_CLKSEL_BIT] = clkSel_q;
        end
        if (hitBoot) begin
            rd_d[`GSFP_BOOT_HSVAL_BIT]    = hsVal_q;
            rd_d[`GSFP_BOOT_DONE_BIT]     = phase_q == gsfp_pkg::GSFP_RUNNING;
            rd_d[`GSFP_BOOT_MODE_LSB +: 3] = bootMode_q;
            rd_d[`GSFP_BOOT_MUX_BIT]      = muxSel_q;
        end
        if (hitFlagCmd || hitStatus1) begin
            rd_d[`GSFP_STATUS1_FLAG] = flag_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_q <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            rd_q <= rd_d;
        end
    end

    assign prdata = rd_q;

    // ------------------------------------------------------------------------
    // Status outputs.
    // ------------------------------------------------------------------------
    assign bootModeSelect       = bootMode_q;                 // [RQ5]
    assign bootActive           = phase_q == gsfp_pkg::GSFP_BOOTING;
    assign clockSourceSelectBit = clkSel_q;

endmodule : gsfp_gpio_port

// file: gsfp_gpio_port_asserts.sv
// Checker of the pin, strap and flag port.
`timescale 1ns/100ps
`include "gsfp_consts.svh"
module gsfp_gpio_port_asserts (
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire gsfp_pkg::gsfp_pins_t gpioIn,
    input wire gsfp_pkg::gsfp_pins_t gpioOut,
    input wire gsfp_pkg::gsfp_pins_t gpioOe,
    input wire logic                 oscillatorClock,
    input wire logic                 externalClockInput,
    input wire logic [2:0]           bootModeSelect,
    input wire logic                 bootActive,
    input wire logic                 clockSourceSelectBit,
    input wire logic                 fastPeripheralClockEn,
    input wire logic                 parallelHostPortSel,
    input wire logic                 externalFlagOutput
);
    default clocking @(posedge core_clk); endclocking
    logic wrAcc;
    assign wrAcc = psel && penable && pwrite;
    dir_reset_a: assert property (rst [*2] |=> gpioOe == 8'h00)
        else $error("pins driven during reset");
    flag_reset_a: assert property (rst [*2] |-> externalFlagOutput)
        else $error("flag low during reset");
    strap_input_a: assert property (disable iff (rst)
        bootActive && $past(bootActive) |-> gpioOe[2:0] == 3'h0)
        else $error("strap pins driven while booting");
    flag_set_a: assert property (disable iff (rst)
        wrAcc && paddr == `GSFP_OFS_FLAGCMD && pwdata[0] |=> externalFlagOutput)
        else $error("flag not set");
    flag_clr_a: assert property (disable iff (rst)
        wrAcc && paddr == `GSFP_OFS_FLAGCMD && pwdata[1:0] == 2'h2 |=> !externalFlagOutput)
        else $error("flag not cleared");
    status_load_a: assert property (disable iff (rst)
        wrAcc && paddr == `GSFP_OFS_STATUS1 && pwdata[0] |=> externalFlagOutput)
        else $error("flag not loaded with one");
    status_zero_a: assert property (disable iff (rst)
        wrAcc && paddr == `GSFP_OFS_STATUS1 && !pwdata[0] |=> !externalFlagOutput)
        else $error("flag not loaded with zero");
    flag_hold_a: assert property (disable iff (rst)
        !(wrAcc && (paddr == `GSFP_OFS_FLAGCMD || paddr == `GSFP_OFS_STATUS1))
        |=> $stable(externalFlagOutput)) else $error("flag changed by itself");
    fast_pulse_a: assert property (disable iff (rst)
        fastPeripheralClockEn |=> !fastPeripheralClockEn) else $error("enable too long");
    mux_follow_a: assert property (disable iff (rst)
        $stable(gpioIn[6]) [*4] |-> parallelHostPortSel == gpioIn[6])
        else $error("mux select not following pin");
    err_access_a: assert property (psel && penable |-> pready
        && pslverr == (paddr > `GSFP_OFS_STATUS1 || paddr[1:0] != 2'h0))
        else $error("wrong access response");
    c_flag_c: cover property (wrAcc && paddr == `GSFP_OFS_FLAGCMD);
    c_err_c: cover property (pslverr);
    c_fast_c: cover property (fastPeripheralClockEn);
endmodule : gsfp_gpio_port_asserts
bind gsfp_gpio_port gsfp_gpio_port_asserts gsfp_gpio_port_asserts_i (.*);

// file: gsfp_board_model.sv
// Board straps, pin resolution and clock sources around the port.
`timescale 1ns/100ps
module gsfp_board_model (
    input wire logic                 rst,
    input wire gsfp_pkg::gsfp_pins_t strap,
    input wire gsfp_pkg::gsfp_pins_t gpioOut,
    input wire gsfp_pkg::gsfp_pins_t gpioOe,
    output gsfp_pkg::gsfp_pins_t     gpioIn,
    output logic                     oscillatorClock,
    output logic                     externalClockInput
);
    gsfp_pkg::gsfp_pins_t pull;
    // Pin 7 is held low while reset is high.
    assign pull = rst ? (strap & 8'h7f) : strap;
    // A driven pin overrides its strap resistor.
    assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & pull);
    initial begin
        oscillatorClock = 1'b0;
        forever #40 oscillatorClock = ~oscillatorClock;
    end
    initial begin
        externalClockInput = 1'b0;
        forever #60 externalClockInput = ~externalClockInput;
    end
endmodule : gsfp_board_model

// file: testbench.sv
// Self-checking bench of the pin, strap and flag port.
`timescale 1ns/100ps
`include "gsfp_consts.svh"
module testbench;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, osc, ext;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] bootMode;
    logic clkSel, muxSel, bootAct, fastEn, flag, err;
    gsfp_pkg::gsfp_pins_t strap, pinIn, pinOut, pinOe;
    int errorCnt, checkCount, fastCnt;

    gsfp_gpio_port gsfp_gpio_port_i (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpioIn(pinIn),
        .gpioOut(pinOut), .gpioOe(pinOe), .oscillatorClock(osc),
        .externalClockInput(ext), .bootModeSelect(bootMode), .bootActive(bootAct),
        .clockSourceSelectBit(clkSel), .fastPeripheralClockEn(fastEn),
        .parallelHostPortSel(muxSel), .externalFlagOutput(flag));
    gsfp_board_model gsfp_board_model_i (.rst(rst), .strap(strap), .gpioOut(pinOut),
        .gpioOe(pinOe), .gpioIn(pinIn), .oscillatorClock(osc), .externalClockInput(ext));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (fastEn === 1'b1) fastCnt++;

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checkCount++;
        if (g !== e) begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : xfer
    task settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle
    task do_reset(input logic [7:0] s);
        strap <= s; rst <= 1'b1;
        settle(4);
        chk("oe_rst", 8'h00, pinOe);
        chk("flag_rst", 1'b1, flag);
        rst <= 1'b0;
        settle(2);
    endtask : do_reset
    task fast_count(input int lo, input int hi);
        int start;
        start = fastCnt;
        settle(384);
        chk("fast_cnt", 1'b1, (fastCnt - start) inside {[lo:hi]});
    endtask : fast_count
    task final_report;
        if (errorCnt == 0 && checkCount > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge core_clk);
        errorCnt++;
        final_report;
    end
    initial begin
        errorCnt = 0; checkCount = 0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        do_reset(8'h55);
        chk("boot_mode", 3'h5, bootMode);
        chk("clk_sel", 1'b1, clkSel);
        chk("hs_drive", 16'h1010, {pinOe, pinOut & 8'h10});
        chk("boot_act", 1'b1, bootAct);
        xfer(0, `GSFP_OFS_DIR, 0); chk("dir", 32'h0, rd);
        xfer(0, `GSFP_OFS_BOOT, 0); chk("boot", 32'hd1, rd);
        fast_count(7, 9);
        xfer(1, `GSFP_OFS_BOOT, 0); settle(2); chk("hs_low", 8'h0, pinOut & 8'h10);
        xfer(1, `GSFP_OFS_DIR, 32'h0f); settle(2); chk("oe_boot", 8'h18, pinOe);
        xfer(1, `GSFP_OFS_BOOT, 32'h2); settle(2); chk("oe_run", 8'h0f, pinOe);
        chk("boot_done", 1'b0, bootAct);
        xfer(1, `GSFP_OFS_DATA, 32'ha5); settle(2); chk("out", 8'h05, pinOut & pinOe);
        strap <= 8'h3c; settle(4);
        xfer(0, `GSFP_OFS_DATA, 0); chk("data", 32'h35, rd);
        chk("mux", 1'b0, muxSel);
        xfer(1, `GSFP_OFS_CLKMODE, 0); xfer(0, `GSFP_OFS_CLKMODE, 0);
        chk("clkmode", 32'h0, rd); chk("clk_sel0", 1'b0, clkSel);
        fast_count(11, 13);
        xfer(1, `GSFP_OFS_FLAGCMD, 32'h2); settle(1); chk("flag_clr", 1'b0, flag);
        xfer(0, `GSFP_OFS_FLAGCMD, 0); chk("flag_rd", 32'h0, rd);
        xfer(1, `GSFP_OFS_FLAGCMD, 32'h3); settle(1); chk("flag_set", 1'b1, flag);
        xfer(1, `GSFP_OFS_STATUS1, 0); settle(1); chk("flag_ld0", 1'b0, flag);
        xfer(1, `GSFP_OFS_STATUS1, 1); settle(1); chk("flag_ld1", 1'b1, flag);
        xfer(0, 12'h018, 0); chk("unmapped_rd", 32'h0, rd);
        chk("unmapped_err", 1'b1, err);
        do_reset(8'h03);
        chk("strap2", 5'h03, {clkSel, pinOe[0], bootMode});
        final_report;
    end
endmodule : testbench
